/* File: hdl/tlv_pkg.sv */
/*
  Constants and carrier types for the two-level vectored interrupt
  controller. Assumes an 8-bit special-function-register space and
  a 16-bit program counter in the core.
*/
package tlv_pkg;

  // ----------------------------------------------------------------
  // Register addresses and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] IRQ_ON_ADDR     = 8'ha8;
  localparam logic [7:0] SECOND_IRQ_ADDR = 8'ha9;
  localparam logic [7:0] IRQ_LEVEL_ADDR  = 8'hb8;
  localparam logic [7:0] IRQ_ON_RST      = 8'h00;
  localparam logic [7:0] SECOND_IRQ_RST  = 8'ha0;
  localparam logic [7:0] IRQ_LEVEL_RST   = 8'h00;
  localparam logic [7:0] BIT_ONE         = 8'h01;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int GLOBAL_ON_BIT   = 7;
  localparam int CONV_BIT        = 6;
  localparam int TMR2_BIT        = 5;
  localparam int UART_BIT        = 4;
  localparam int TMR1_BIT        = 3;
  localparam int PIN1_BIT        = 2;
  localparam int TMR0_BIT        = 1;
  localparam int PIN0_BIT        = 0;
  localparam int RSVD_BIT        = 7;
  localparam int INTERVAL_LV_BIT = 6;
  localparam int SUPPLY_LV_BIT   = 5;
  localparam int SYNC_LV_BIT     = 4;
  localparam int INTERVAL_ON_BIT = 2;
  localparam int SUPPLY_ON_BIT   = 1;
  localparam int SYNC_ON_BIT     = 0;

  // ----------------------------------------------------------------
  // Sources in polling order, index 0 is served first
  // ----------------------------------------------------------------
  localparam int NUM_SRC = 11;
  localparam logic [15:0] PC_VEC [NUM_SRC] = '{
    16'h0043, 16'h005b, 16'h0003, 16'h0033, 16'h000b, 16'h0013,
    16'h001b, 16'h003b, 16'h0023, 16'h002b, 16'h0053};

  // Packed MSB first, so bit 0 is the supply monitor.
  typedef struct packed {
    logic interval_flag;
    logic tmr2_flags;
    logic uart_rx_tx_flags;
    logic sync_serial_flag;
    logic tmr1_overflow;
    logic pin1_flag;
    logic tmr0_overflow;
    logic conv_done_flag;
    logic pin0_flag;
    logic watchdog_flag;
    logic supply_mon_flag;
  } tlv_src_t;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } tlv_byte_wr_t;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic       val;
  } tlv_bit_wr_t;

endpackage : tlv_pkg

/* File: hdl/tlv_irq_ctrl.sv */
/*
  Two-level vectored interrupt controller: enable, level and second
  registers, arbitration, and the push/load sequence toward the core.
  Assumes source flags and register strobes are synchronous to clk and
  that the core pushes its PC on push_pc, jumps on load_pc and pulses
  ret_done on each return from a handler.
*/
// What this block does
// - Global enable at 0 blocks all sources; at 1 enabled sources run.
// - Enable register: one bit per source, conversion in 6 down to pin0.
// - Level register: one bit per source, 1 high; bit 7 reserved.
// - Second register levels: interval 6, supply 5, sync serial 4.
// - Second register enables: interval 2, supply 1, sync serial 0.
// - Second resets to a0 and is byte-only; others reset 00, bit access.
// - A high request may preempt a low-level handler.
// - When levels collide, the high request is dispatched first.
// - A handler is never preempted by a request of its own level.
// - Same-level ties follow the fixed polling order.
// - Supply monitor leads the polling order.
// - Accepting a request first makes the core push its PC.
// - Then the PC gets the vector; first five vectors per source.
// - Remaining six vectors per source.
module tlv_irq_ctrl (
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire tlv_pkg::tlv_byte_wr_t byte_wr,
  input  wire tlv_pkg::tlv_bit_wr_t  bit_wr,
  input  wire logic [7:0]            rd_addr,
  input  wire tlv_pkg::tlv_src_t     src,
  input  wire logic                  ret_done,
  output logic [7:0]                 rd_data,
  output logic                       push_pc,
  output logic                       load_pc,
  output logic [15:0]                pc_vector,
  output logic                       in_high,
  output logic                       in_low
);
  import tlv_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_PUSH, ST_LOAD} tlv_state_t;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] irq_on_reg;
  logic [7:0] irq_level_reg;
  logic [7:0] second_irq_reg;
  tlv_state_t state;
  logic [3:0] pend_idx;
  logic       pend_high;

  wire on_bw  = bit_wr.wr && bit_wr.addr[7:3] == IRQ_ON_ADDR[7:3];
  wire lvl_bw = bit_wr.wr && bit_wr.addr[7:3] == IRQ_LEVEL_ADDR[7:3];
  wire [7:0] bit_clr = ~(BIT_ONE << bit_wr.addr[2:0]);
  wire [7:0] bit_set = {7'h00, bit_wr.val} << bit_wr.addr[2:0];

  wire [7:0] next_irq_on =
    (byte_wr.wr && byte_wr.addr == IRQ_ON_ADDR) ? byte_wr.data :
    on_bw ? ((irq_on_reg & bit_clr) | bit_set) : irq_on_reg;
  wire [7:0] lvl_raw =
    (byte_wr.wr && byte_wr.addr == IRQ_LEVEL_ADDR) ? byte_wr.data :
    lvl_bw ? ((irq_level_reg & bit_clr) | bit_set) : irq_level_reg;
  // The reserved top bit cannot be set, so it always reads zero.
  wire [7:0] next_irq_level = lvl_raw & ~(BIT_ONE << RSVD_BIT);
  // Reserved top bit holds its reset value of one; bit 3 is stored as
  // written because software is trusted to keep it zero.
  wire [7:0] next_second =
    (byte_wr.wr && byte_wr.addr == SECOND_IRQ_ADDR) ?
    (byte_wr.data | (BIT_ONE << RSVD_BIT)) : second_irq_reg;

  wire [7:0] next_rd_data =
    (rd_addr == IRQ_ON_ADDR)     ? irq_on_reg :
    (rd_addr == IRQ_LEVEL_ADDR)  ? irq_level_reg :
    (rd_addr == SECOND_IRQ_ADDR) ? second_irq_reg : 8'h00;

  // ----------------------------------------------------------------
  // Per-source enable and level in polling order
  // ----------------------------------------------------------------
  // The watchdog has no enable or level bit, so it is always enabled
  // at high level and can still be held off by the global enable.
  wire [NUM_SRC-1:0] src_on = {
    second_irq_reg[INTERVAL_ON_BIT], irq_on_reg[TMR2_BIT],
    irq_on_reg[UART_BIT], second_irq_reg[SYNC_ON_BIT],
    irq_on_reg[TMR1_BIT], irq_on_reg[PIN1_BIT], irq_on_reg[TMR0_BIT],
    irq_on_reg[CONV_BIT], irq_on_reg[PIN0_BIT], 1'b1,
    second_irq_reg[SUPPLY_ON_BIT]};
  wire [NUM_SRC-1:0] src_high = {
    second_irq_reg[INTERVAL_LV_BIT], irq_level_reg[TMR2_BIT],
    irq_level_reg[UART_BIT], second_irq_reg[SYNC_LV_BIT],
    irq_level_reg[TMR1_BIT], irq_level_reg[PIN1_BIT],
    irq_level_reg[TMR0_BIT], irq_level_reg[CONV_BIT],
    irq_level_reg[PIN0_BIT], 1'b1,
    second_irq_reg[SUPPLY_LV_BIT]};

  wire [NUM_SRC-1:0] req =
    src & src_on & {NUM_SRC{irq_on_reg[GLOBAL_ON_BIT]}};
  wire [NUM_SRC-1:0] hi_req = req & src_high;
  wire [NUM_SRC-1:0] lo_req = req & ~src_high;

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  logic [3:0] hi_idx;
  logic [3:0] lo_idx;
  always_comb begin
    hi_idx = 4'h0;
    lo_idx = 4'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (hi_req[i]) hi_idx = 4'(i);
      if (lo_req[i]) lo_idx = 4'(i);
    end
  end

  wire take_hi = (|hi_req) && !in_high;
  wire take_lo = (|lo_req) && !in_high && !in_low;
  wire grant   = state == ST_IDLE && (take_hi || take_lo);
  wire [3:0] pick = take_hi ? hi_idx : lo_idx;

  // A return clears the innermost level; a dispatch in the same cycle
  // then sets its own level, so the new handler is never lost.
  wire ret_hi = ret_done && in_high;
  wire ret_lo = ret_done && !in_high;
  wire enter  = state == ST_LOAD;
  wire next_in_high = (in_high && !ret_hi) || (enter && pend_high);
  wire next_in_low  = (in_low && !ret_lo) || (enter && !pend_high);

  tlv_state_t next_state;
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: if (grant) next_state = ST_PUSH;
      ST_PUSH: next_state = ST_LOAD;
      ST_LOAD: next_state = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // State and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      irq_on_reg     <= IRQ_ON_RST;
      irq_level_reg  <= IRQ_LEVEL_RST;
      second_irq_reg <= SECOND_IRQ_RST;
    end else begin
      irq_on_reg     <= next_irq_on;
      irq_level_reg  <= next_irq_level;
      second_irq_reg <= next_second;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state     <= ST_IDLE;
      pend_idx  <= 4'h0;
      pend_high <= 1'b0;
      push_pc   <= 1'b0;
      load_pc   <= 1'b0;
      pc_vector <= 16'h0000;
      in_high   <= 1'b0;
      in_low    <= 1'b0;
      rd_data   <= 8'h00;
    end else begin
      state   <= next_state;
      push_pc <= grant;
      load_pc <= state == ST_PUSH;
      in_high <= next_in_high;
      in_low  <= next_in_low;
      rd_data <= next_rd_data;
      if (grant) begin
        pend_idx  <= pick;
        pend_high <= take_hi;
      end
      if (state == ST_PUSH) pc_vector <= PC_VEC[pend_idx];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_global_gate: assert property (@(posedge clk) disable iff (!rstn)
    !irq_on_reg[GLOBAL_ON_BIT] |-> !grant)
    else $error("Dispatch while global enable is off.");

  a_bit_write: assert property (@(posedge clk) disable iff (!rstn)
    (on_bw && !byte_wr.wr) |=> irq_on_reg[$past(bit_wr.addr[2:0])]
      == $past(bit_wr.val))
    else $error("Bit write to enable register lost.");

  a_reset_second: assert property (@(posedge clk)
    !rstn |=> second_irq_reg == SECOND_IRQ_RST && irq_on_reg == IRQ_ON_RST)
    else $error("Register reset value wrong.");

  a_preempt_low: assert property (@(posedge clk) disable iff (!rstn)
    (state == ST_IDLE && in_low && !in_high && |hi_req)
      |=> push_pc ##2 in_high)
    else $error("High request did not preempt low handler.");

  a_high_first: assert property (@(posedge clk) disable iff (!rstn)
    (grant && |hi_req && !in_high) |-> hi_req[pick])
    else $error("Low request served ahead of high one.");

  a_same_level: assert property (@(posedge clk) disable iff (!rstn)
    in_high |-> !grant)
    else $error("High handler preempted.");

  a_poll_order: assert property (@(posedge clk) disable iff (!rstn)
    grant |-> ((take_hi ? hi_req : lo_req)
      & ((11'h001 << pick) - 11'h001)) == 11'h000)
    else $error("Polling order broken.");

  a_supply_first: assert property (@(posedge clk) disable iff (!rstn)
    (grant && req[0] && (src_high[0] == take_hi)) |-> pick == 4'h0)
    else $error("Supply monitor not first.");

  a_push_load: assert property (@(posedge clk) disable iff (!rstn)
    push_pc |=> load_pc && !push_pc)
    else $error("Load did not follow push.");

  a_vector_ok: assert property (@(posedge clk) disable iff (!rstn)
    grant |-> ##2 (load_pc && pc_vector == PC_VEC[$past(pick, 2)]))
    else $error("Wrong vector loaded.");

endmodule : tlv_irq_ctrl

/* File: verification/tlv_core_model.sv */
/*
  Core-side model of the vectored controller's partner.
  Assumes push_pc precedes load_pc and ret_go is a one-cycle pulse.
*/
module tlv_core_model (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        push_pc,
  input  wire logic        load_pc,
  input  wire logic [15:0] pc_vector,
  input  wire logic        ret_go,
  output logic             ret_done,
  output logic [15:0]      last_vec,
  output logic [7:0]       depth
);
  timeunit 1ns;
  timeprecision 1ns;
  logic pushed;
  // A load without a prior push is ignored, so a bad order shows.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pushed   <= 1'b0;
      depth    <= 8'h00;
      last_vec <= 16'h0000;
      ret_done <= 1'b0;
    end else begin
      ret_done <= ret_go;
      if (push_pc) pushed <= 1'b1;
      if (load_pc && pushed) begin
        last_vec <= pc_vector;
        depth    <= depth + 8'h01;
        pushed   <= 1'b0;
      end
      if (ret_go) depth <= depth - 8'h01;
    end
  end
endmodule : tlv_core_model

/* File: verification/testbench.sv */
/*
  Self-checking bench for the vectored interrupt controller.
  Assumes the core model answers pushes, loads and returns.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import tlv_pkg::*;
  logic clk = 0, rstn = 0, ret_go = 0, ret_done;
  logic push_pc, load_pc, in_high, in_low;
  tlv_byte_wr_t byte_wr = '0;
  tlv_bit_wr_t  bit_wr = '0;
  tlv_src_t     src = '0;
  logic [7:0]   rd_addr = 8'h00, rd_data, depth;
  logic [15:0]  pc_vector, last_vec;
  int           n_errors = 0, total_checks = 0;
  logic [15:0]  vec [11] = '{16'h0043, 16'h005b, 16'h0003, 16'h0033,
    16'h000b, 16'h0013, 16'h001b, 16'h003b, 16'h0023, 16'h002b, 16'h0053};
  always #10 clk = ~clk;
  tlv_irq_ctrl dut (.clk, .rstn, .byte_wr, .bit_wr, .rd_addr, .src,
    .ret_done, .rd_data, .push_pc, .load_pc, .pc_vector, .in_high,
    .in_low);
  tlv_core_model core (.clk, .rstn, .push_pc, .load_pc, .pc_vector,
    .ret_go, .ret_done, .last_vec, .depth);
  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wb(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk) byte_wr = {1'b1, a, d};
    @(negedge clk) byte_wr.wr = 1'b0;
  endtask : wb
  task wbit(input logic [7:0] a, input logic v);
    @(negedge clk) bit_wr = {1'b1, a, v};
    @(negedge clk) bit_wr.wr = 1'b0;
  endtask : wbit
  task rd(input logic [7:0] a, input logic [7:0] e);
    rd_addr = a;
    repeat (2) @(negedge clk);
    chk({8'h00, rd_data}, {8'h00, e});
  endtask : rd
  // Waits a bounded time for a push, then lets the load land.
  task grant(input logic [15:0] e);
    int k;
    k = 0;
    while (push_pc !== 1'b1 && k < 30) begin
      @(negedge clk);
      k++;
    end
    repeat (2) @(negedge clk);
    chk(last_vec, e);
  endtask : grant
  task quiet();
    logic seen;
    seen = 1'b0;
    repeat (8) @(negedge clk) if (push_pc !== 1'b0) seen = 1'b1;
    chk({15'h0, seen}, 16'h0000);
  endtask : quiet
  task ret();
    @(negedge clk) ret_go = 1'b1;
    @(negedge clk) ret_go = 1'b0;
  endtask : ret
  task t_regs();
    rd(IRQ_ON_ADDR, 8'h00);
    rd(SECOND_IRQ_ADDR, 8'ha0);
    rd(IRQ_LEVEL_ADDR, 8'h00);
    rd(8'h55, 8'h00);
    wb(IRQ_LEVEL_ADDR, 8'hff);
    rd(IRQ_LEVEL_ADDR, 8'h7f);
    wb(SECOND_IRQ_ADDR, 8'h77);
    rd(SECOND_IRQ_ADDR, 8'hf7);
    wbit(8'hae, 1'b1);
    wbit(8'ha9, 1'b1);
    rd(IRQ_ON_ADDR, 8'h42);
    rd(SECOND_IRQ_ADDR, 8'hf7);
    wbit(8'hbf, 1'b1);
    wbit(8'hb8, 1'b0);
    rd(IRQ_LEVEL_ADDR, 8'h7e);
    wb(IRQ_LEVEL_ADDR, 8'h00);
    wb(SECOND_IRQ_ADDR, 8'h00);
    rd(SECOND_IRQ_ADDR, 8'h80);
    $display("register test done");
  endtask : t_regs
  task t_global();
    wb(IRQ_ON_ADDR, 8'h01);
    src.pin0_flag = 1'b1;
    quiet();
    wbit(8'haf, 1'b1);
    grant(16'h0003);
    chk({15'h0, in_low}, 16'h0001);
    src = '0;
    ret();
    $display("global enable test done");
  endtask : t_global
  // Every source but the watchdog at low level, served in turn.
  task t_poll();
    wb(SECOND_IRQ_ADDR, 8'h07);
    wb(IRQ_ON_ADDR, 8'hff);
    src = 11'h7fd;
    for (int i = 0; i < 11; i++) begin
      if (i != 1) begin
        grant(vec[i]);
        src[i] = 1'b0;
        ret();
      end
    end
    $display("polling test done");
  endtask : t_poll
  task t_level();
    wbit(8'hbc, 1'b1);
    src = 11'h301;
    grant(16'h0023);
    chk({15'h0, in_high}, 16'h0001);
    src.watchdog_flag = 1'b1;
    quiet();
    src.uart_rx_tx_flags = 1'b0;
    ret();
    grant(16'h005b);
    src.watchdog_flag = 1'b0;
    ret();
    grant(16'h0043);
    src.uart_rx_tx_flags = 1'b1;
    grant(16'h0023);
    chk({8'h00, depth}, 16'h0002);
    src = '0;
    ret();
    ret();
    @(negedge clk);
    chk({14'h0, in_high, in_low}, 16'h0000);
    $display("level test done");
  endtask : t_level
  task tally_and_finish();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    t_regs();
    t_global();
    t_poll();
    t_level();
    tally_and_finish();
  end
  // The tests need well under 2000 cycles; this is a generous limit.
  initial begin
    #100000;
    n_errors++;
    tally_and_finish();
  end
endmodule : testbench
